// File: hdl/afc_results.sv
// Flag-clear, interrupt flag, conversion result and accumulated result registers
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Writing 0 to bit 6 clears overflow
// - Bits 5,4,3 written 0 clear watchdog flags
// - Bits 2,1,0 written 0 clear done flags
// - Writing 1 to a clear bit does nothing
// - Clear register resets 0x7F, reads 0x7F
// - Four read-only 16-bit result registers, reset zero
// - Read-only 24-bit accumulated result, reset zero
// - Overflow set when unread result is overwritten
// - Flag register read-only, seven flags, reset zero
////////////////////////////////////////////////////////////////////////////////
module afc_results #(
	parameter int RES_W = afc_pkg::RES_W_DOC,
	parameter int ACC_W = afc_pkg::ACC_W_DOC
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rst_n,
	input  wire logic                         clk_en,
	input  wire logic [afc_pkg::ADDR_W-1:0]   bus_addr,
	input  wire logic [afc_pkg::DATA_W-1:0]   bus_wdata,
	input  wire logic                         bus_wr,
	input  wire logic                         bus_rd,
	output logic      [afc_pkg::DATA_W-1:0]   bus_rdata,
	input  wire logic                         conv_done,
	input  wire logic [afc_pkg::SLOT_W-1:0]   conv_slot,
	input  wire logic [RES_W-1:0]             conv_result,
	input  wire logic                         seq_done,
	input  wire logic                         multi_done,
	input  wire logic                         wd_in_window,
	input  wire logic                         wd_upper,
	input  wire logic                         wd_lower,
	input  wire logic                         acc_clear,
	output logic      [afc_pkg::FLAG_N-1:0]   interrupt_flag
);

	if (RES_W < 1 || RES_W > afc_pkg::RES_W_DOC) begin : g_chk_res
		$error("RES_W must lie between 1 and 16");
	end
	if (ACC_W < RES_W || ACC_W > afc_pkg::ACC_W_DOC) begin : g_chk_acc
		$error("ACC_W must lie between RES_W and 24");
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	logic [RES_W-1:0]                 result_mem [afc_pkg::SLOT_N];
	logic [afc_pkg::SLOT_N-1:0]       unread;
	logic [ACC_W-1:0]                 acc;
	logic [afc_pkg::FLAG_N-1:0]       next_flag;
	logic [afc_pkg::DATA_W-1:0]       next_rdata;
	logic [afc_pkg::SLOT_N-1:0]       res_rd_hit;
	logic [afc_pkg::SLOT_N-1:0]       slot_wr;
	logic [afc_pkg::DATA_W-1:0]       res_word [afc_pkg::SLOT_N];

	wire                              acc_rd_hit  = bus_rd && bus_addr == afc_pkg::OFF_ACC;
	wire                              clr_rd_hit  = bus_rd && bus_addr == afc_pkg::OFF_FLAG_CLR;
	wire                              flag_rd_hit = bus_rd && bus_addr == afc_pkg::OFF_FLAG;
	wire                              clr_wr_hit  = bus_wr && bus_addr == afc_pkg::OFF_FLAG_CLR;
	// Zeros in the written word pick the flags to clear; ones are ignored
	wire  [afc_pkg::FLAG_N-1:0]       clr_vec     = clr_wr_hit ?
		~bus_wdata[afc_pkg::FLAG_N-1:0] : '0;
	wire                              overflow_set = conv_done && unread[conv_slot];
	wire  [afc_pkg::FLAG_N-1:0]       set_vec     = {overflow_set, wd_in_window, wd_upper,
		wd_lower, multi_done, seq_done, conv_done};

	////////////////////////////////////////////////////////////////////////////
	// Result slots with their unread markers
	for (genvar k = 0; k < afc_pkg::SLOT_N; k++) begin : g_slot
		localparam logic [afc_pkg::ADDR_W-1:0] SLOT_OFF = afc_pkg::ADDR_W'(
			afc_pkg::OFF_RESULT0 + k * afc_pkg::SLOT_STRIDE);
		assign res_rd_hit[k] = bus_rd && bus_addr == SLOT_OFF;
		assign slot_wr[k]    = conv_done && conv_slot == afc_pkg::SLOT_W'(k);
		assign res_word[k]   = afc_pkg::DATA_W'(result_mem[k]);

		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				result_mem[k] <= '0;
				unread[k]     <= 1'b0;
			end else if (clk_en) begin
				if (slot_wr[k]) begin
					result_mem[k] <= conv_result;
				end
				// A fresh result in the read cycle stays unread
				unread[k] <= slot_wr[k] || (unread[k] && !res_rd_hit[k]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and accumulator
	assign next_flag = (interrupt_flag & ~clr_vec) | set_vec;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_flag <= '0;
			acc            <= '0;
		end else if (clk_en) begin
			interrupt_flag <= next_flag;
			if (acc_clear) begin
				acc <= '0;
			end else if (conv_done) begin
				acc <= ACC_W'(acc + ACC_W'(conv_result));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; data stands only in the cycle after the strobe
	always_comb begin
		next_rdata = afc_pkg::ZERO_WORD;
		for (int i = 0; i < afc_pkg::SLOT_N; i++) begin
			if (res_rd_hit[i]) begin
				next_rdata = res_word[i];
			end
		end
		if (acc_rd_hit) begin
			next_rdata = afc_pkg::DATA_W'(acc);
		end
		if (clr_rd_hit) begin
			next_rdata = afc_pkg::FLAG_CLR_RESET;
		end
		if (flag_rd_hit) begin
			next_rdata = afc_pkg::DATA_W'(interrupt_flag);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= afc_pkg::ZERO_WORD;
		end else if (clk_en) begin
			bus_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_clear(int b);
		clk_en && clr_wr_hit && !bus_wdata[b] && !set_vec[b];
	endsequence
	sequence s_keep(int b);
		clk_en && clr_wr_hit && bus_wdata[b] && !set_vec[b];
	endsequence

	property p_clear_overflow;
		s_clear(afc_pkg::BIT_OVERFLOW) |=> !interrupt_flag[afc_pkg::BIT_OVERFLOW];
	endproperty
	a_clear_overflow: assert property (p_clear_overflow) else $error("overflow not cleared");

	property p_clear_watchdog;
		s_clear(afc_pkg::BIT_WD_IN) or s_clear(afc_pkg::BIT_WD_UPPER)
			or s_clear(afc_pkg::BIT_WD_LOWER)
		|=> (interrupt_flag[afc_pkg::BIT_WD_IN:afc_pkg::BIT_WD_LOWER]
			& ~$past(bus_wdata[afc_pkg::BIT_WD_IN:afc_pkg::BIT_WD_LOWER])
			& ~$past(set_vec[afc_pkg::BIT_WD_IN:afc_pkg::BIT_WD_LOWER])) == '0;
	endproperty
	a_clear_watchdog: assert property (p_clear_watchdog) else $error("watchdog flag stuck");

	property p_clear_done;
		clk_en && clr_wr_hit
		|=> (interrupt_flag[afc_pkg::BIT_MULTI_DONE:afc_pkg::BIT_CONV_DONE]
			& ~$past(bus_wdata[afc_pkg::BIT_MULTI_DONE:afc_pkg::BIT_CONV_DONE])
			& ~$past(set_vec[afc_pkg::BIT_MULTI_DONE:afc_pkg::BIT_CONV_DONE])) == '0;
	endproperty
	a_clear_done: assert property (p_clear_done) else $error("done flag stuck");

	property p_one_keeps;
		s_keep(afc_pkg::BIT_OVERFLOW) |=> $stable(interrupt_flag[afc_pkg::BIT_OVERFLOW]);
	endproperty
	a_one_keeps: assert property (p_one_keeps) else $error("write of one changed flag");

	property p_clear_reads_ones;
		clk_en && clr_rd_hit |=> bus_rdata == afc_pkg::FLAG_CLR_RESET;
	endproperty
	a_clear_reads_ones: assert property (p_clear_reads_ones) else $error("clear reg read");

	property p_result_read;
		clk_en && conv_done ##1 clk_en && bus_rd
			&& bus_addr == afc_pkg::ADDR_W'(afc_pkg::OFF_RESULT0
				+ $past(conv_slot) * afc_pkg::SLOT_STRIDE)
		|=> bus_rdata == afc_pkg::DATA_W'($past(conv_result, 2));
	endproperty
	a_result_read: assert property (p_result_read) else $error("result readback wrong");

	property p_acc_sum;
		clk_en && conv_done && !acc_clear
		|=> acc == ACC_W'($past(acc) + ACC_W'($past(conv_result)));
	endproperty
	a_acc_sum: assert property (p_acc_sum) else $error("accumulator wrong");

	property p_overflow_set;
		clk_en && conv_done ##1 clk_en && conv_done && conv_slot == $past(conv_slot)
			&& !res_rd_hit[conv_slot]
		|=> interrupt_flag[afc_pkg::BIT_OVERFLOW];
	endproperty
	a_overflow_set: assert property (p_overflow_set) else $error("overflow missed");

	property p_flag_read;
		clk_en && flag_rd_hit |=> bus_rdata == afc_pkg::DATA_W'($past(interrupt_flag));
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

	property p_set_wins;
		clk_en && clr_wr_hit && conv_done |=> interrupt_flag[afc_pkg::BIT_CONV_DONE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

	////////////////////////////////////////////////////////////////////////////
	// Checks on setting, holding and freezing

	// Read data is a one-cycle answer, so idle cycles return zero
	property p_rdata_idle;
		clk_en && !bus_rd |=> bus_rdata == afc_pkg::ZERO_WORD;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	// Enable low must hold flags, read data, accumulator and unread marks still
	property p_freeze;
		!clk_en |=> $stable(interrupt_flag) && $stable(bus_rdata) && $stable(acc)
			&& $stable(unread);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	// Clear wins over a same-cycle conversion in the accumulator
	property p_acc_clear;
		clk_en && acc_clear |=> acc == '0;
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");

	// Upper bits of the accumulated word read as zero
	property p_acc_read;
		clk_en && acc_rd_hit |=> bus_rdata == afc_pkg::DATA_W'($past(acc));
	endproperty
	a_acc_read: assert property (p_acc_read) else $error("accumulator readback wrong");

	// Sequence event reaches its flag
	property p_seq_set;
		clk_en && seq_done |=> interrupt_flag[afc_pkg::BIT_SEQ_DONE];
	endproperty
	a_seq_set: assert property (p_seq_set) else $error("sequence flag missed");

	// Multiple-conversion event reaches its flag
	property p_multi_set;
		clk_en && multi_done |=> interrupt_flag[afc_pkg::BIT_MULTI_DONE];
	endproperty
	a_multi_set: assert property (p_multi_set) else $error("multi flag missed");

	// Watchdog events reach their flags
	property p_wd_set;
		clk_en && (wd_in_window || wd_upper || wd_lower)
		|=> (interrupt_flag[afc_pkg::BIT_WD_IN:afc_pkg::BIT_WD_LOWER]
			& $past({wd_in_window, wd_upper, wd_lower})) == $past({wd_in_window, wd_upper, wd_lower});
	endproperty
	a_wd_set: assert property (p_wd_set) else $error("watchdog flag missed");

	// Conversion event reaches its flag
	property p_conv_set;
		clk_en && conv_done |=> interrupt_flag[afc_pkg::BIT_CONV_DONE];
	endproperty
	a_conv_set: assert property (p_conv_set) else $error("done flag missed");

	// No conversion done flag appears without its event
	property p_no_spurious_done;
		$rose(interrupt_flag[afc_pkg::BIT_CONV_DONE]) |-> $past(clk_en && conv_done);
	endproperty
	a_no_spurious_done: assert property (p_no_spurious_done) else $error("spurious done");

	// Overflow only follows an overwrite of an unread slot
	property p_overflow_cause;
		$rose(interrupt_flag[afc_pkg::BIT_OVERFLOW]) |-> $past(clk_en && overflow_set);
	endproperty
	a_overflow_cause: assert property (p_overflow_cause) else $error("spurious overflow");

	// A fresh result in slot 0 is always marked unread
	property p_unread_mark;
		clk_en && slot_wr[0] |=> unread[0];
	endproperty
	a_unread_mark: assert property (p_unread_mark) else $error("unread mark missing");

	// The slot 0 result changes only when slot 0 is written
	property p_result_hold;
		clk_en && !slot_wr[0] |=> $stable(result_mem[0]);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed");

	// A one leaves the done flag alone
	property p_keep_done;
		s_keep(afc_pkg::BIT_CONV_DONE) |=> $stable(interrupt_flag[afc_pkg::BIT_CONV_DONE]);
	endproperty
	a_keep_done: assert property (p_keep_done) else $error("done flag changed by one");

	// A one leaves the upper watchdog flag alone
	property p_keep_upper;
		s_keep(afc_pkg::BIT_WD_UPPER) |=> $stable(interrupt_flag[afc_pkg::BIT_WD_UPPER]);
	endproperty
	a_keep_upper: assert property (p_keep_upper) else $error("upper flag changed by one");

	// A zero clears the sequence flag when no event competes
	property p_clear_seq;
		s_clear(afc_pkg::BIT_SEQ_DONE) |=> !interrupt_flag[afc_pkg::BIT_SEQ_DONE];
	endproperty
	a_clear_seq: assert property (p_clear_seq) else $error("sequence flag stuck");

endmodule

// File: shared/afc_pkg.sv
// Package with register map, field layout and widths of the flag-clear and result bank
package afc_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          FLAG_N          = 7;
	localparam int          SLOT_N          = 4;
	localparam int          SLOT_W          = 2;
	localparam int          RES_W_DOC       = 16;
	localparam int          ACC_W_DOC       = 24;

	localparam logic [ADDR_W-1:0] OFF_RESULT0 = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_RESULT1 = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_RESULT2 = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_RESULT3 = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_ACC     = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_FLAG_CLR = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_FLAG    = 8'h3C;
	localparam logic [ADDR_W-1:0] SLOT_STRIDE = 8'h04;

	localparam logic [DATA_W-1:0] FLAG_CLR_RESET = 32'h0000007F;
	localparam logic [DATA_W-1:0] ZERO_WORD      = 32'h00000000;

	// Bit positions shared by flag and flag-clear registers
	localparam int          BIT_OVERFLOW    = 6;
	localparam int          BIT_WD_IN       = 5;
	localparam int          BIT_WD_UPPER    = 4;
	localparam int          BIT_WD_LOWER    = 3;
	localparam int          BIT_MULTI_DONE  = 2;
	localparam int          BIT_SEQ_DONE    = 1;
	localparam int          BIT_CONV_DONE   = 0;
endpackage

// File: testbench/afc_results_tb.sv
// Self-checking testbench for the flag-clear and result register bank
`timescale 1ns/1ns
module afc_results_tb;
	logic                       sys_clk      = 1'b0;
	logic                       rst_n        = 1'b0;
	logic                       clk_en       = 1'b1;
	logic [afc_pkg::ADDR_W-1:0] bus_addr     = 8'h00;
	logic [afc_pkg::DATA_W-1:0] bus_wdata    = 32'h00000000;
	logic                       bus_wr       = 1'b0;
	logic                       bus_rd       = 1'b0;
	logic [afc_pkg::DATA_W-1:0] bus_rdata;
	logic                       conv_done    = 1'b0;
	logic [1:0]                 conv_slot    = 2'h0;
	logic [15:0]                conv_result  = 16'h0000;
	logic                       seq_done     = 1'b0;
	logic                       multi_done   = 1'b0;
	logic                       wd_in_window = 1'b0;
	logic                       wd_upper     = 1'b0;
	logic                       wd_lower     = 1'b0;
	logic                       acc_clear    = 1'b0;
	logic [6:0]                 interrupt_flag;
	int                         fails        = 0;
	int                         num_checks   = 0;
	logic [6:0]                 m_flag       = 7'h00;
	logic [15:0]                m_res [4];
	logic [23:0]                m_acc        = 24'h000000;
	logic [3:0]                 m_unread     = 4'h0;
	logic [15:0]                rnd          = 16'h281B;

	always #2 sys_clk = ~sys_clk;

	afc_results i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.conv_done(conv_done), .conv_slot(conv_slot), .conv_result(conv_result),
		.seq_done(seq_done), .multi_done(multi_done), .wd_in_window(wd_in_window),
		.wd_upper(wd_upper), .wd_lower(wd_lower), .acc_clear(acc_clear),
		.interrupt_flag(interrupt_flag));
////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] expect_at(input logic [7:0] a);
		if (a == afc_pkg::OFF_FLAG) return {25'h0000000, m_flag};
		if (a == afc_pkg::OFF_FLAG_CLR) return afc_pkg::FLAG_CLR_RESET;
		if (a == afc_pkg::OFF_ACC) return {8'h00, m_acc};
		if (a >= 8'h20 && a <= 8'h2C && a[1:0] == 2'h0) return {16'h0000, m_res[a[3:2]]};
		return afc_pkg::ZERO_WORD;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t read 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a);
		logic [31:0] e;
		e = expect_at(a);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		check(bus_rdata, e);
		// A slot read drops its unread mark
		if (a >= 8'h20 && a <= 8'h2C) m_unread[a[3:2]] = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		if (a == afc_pkg::OFF_FLAG_CLR) m_flag = m_flag & d[6:0];
	endtask

	// Events, optionally with a flag-clear write in the very same cycle
	task automatic pulse(input logic [6:0] m, input logic [1:0] s, input logic [15:0] v,
		input logic clr, input logic [31:0] cd);
		@(posedge sys_clk);
		{wd_in_window, wd_upper, wd_lower, multi_done, seq_done, conv_done} <= m[5:0];
		conv_slot <= s;
		conv_result <= v;
		bus_wr <= clr;
		bus_addr <= afc_pkg::OFF_FLAG_CLR;
		bus_wdata <= cd;
		@(posedge sys_clk);
		{wd_in_window, wd_upper, wd_lower, multi_done, seq_done, conv_done} <= 6'h00;
		bus_wr <= 1'b0;
		if (clr) m_flag = m_flag & cd[6:0];
		if (m[0]) begin
			if (m_unread[s]) m_flag[6] = 1'b1;
			m_res[s] = v;
			m_unread[s] = 1'b1;
			m_acc = m_acc + {8'h00, v};
		end
		m_flag[5:0] = m_flag[5:0] | m[5:0];
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		fails++;
		wrap_up;
	end

	initial begin
		for (int i = 0; i < 4; i++) m_res[i] = 16'h0000;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 8'h20; a <= 8'h3C; a += 4) rd_chk(a[7:0]);
		rd_chk(8'h10);
		wr(afc_pkg::OFF_FLAG_CLR, 32'h00000000);
		rd_chk(afc_pkg::OFF_FLAG_CLR);
		pulse(7'h3F, 2'h1, 16'hFFFF, 1'b0, 32'h0);
		pulse(7'h01, 2'h1, 16'hFFFF, 1'b0, 32'h0);
		rd_chk(afc_pkg::OFF_FLAG);
		// Read-only places must ignore writes
		wr(afc_pkg::OFF_FLAG, 32'h00000000);
		wr(afc_pkg::OFF_RESULT1, 32'h00000000);
		rd_chk(afc_pkg::OFF_FLAG);
		rd_chk(afc_pkg::OFF_RESULT1);
		for (int b = 6; b >= 0; b--) begin
			wr(afc_pkg::OFF_FLAG_CLR, ~(32'h00000001 << b));
			rd_chk(afc_pkg::OFF_FLAG);
		end
		pulse(7'h01, 2'h2, 16'h1234, 1'b1, 32'h0000007E);
		rd_chk(afc_pkg::OFF_FLAG);
		@(posedge sys_clk);
		acc_clear <= 1'b1;
		@(posedge sys_clk);
		acc_clear <= 1'b0;
		m_acc = 24'h000000;
		rd_chk(afc_pkg::OFF_ACC);
		// Back-to-back results to one slot, read in the middle cycle
		@(posedge sys_clk);
		conv_done <= 1'b1;
		conv_slot <= 2'h3;
		conv_result <= 16'hA5A5;
		@(posedge sys_clk);
		conv_result <= 16'h5A5A;
		bus_rd <= 1'b1;
		bus_addr <= afc_pkg::OFF_RESULT3;
		@(posedge sys_clk);
		conv_result <= 16'h0F0F;
		bus_rd <= 1'b0;
		#1;
		check(bus_rdata, 32'h0000A5A5);
		@(posedge sys_clk);
		conv_done <= 1'b0;
		m_res[3] = 16'h0F0F;
		m_unread[3] = 1'b1;
		m_flag[6] = 1'b1;
		m_flag[0] = 1'b1;
		m_acc = m_acc + 24'h00A5A5 + 24'h005A5A + 24'h000F0F;
		rd_chk(afc_pkg::OFF_FLAG);
		rd_chk(afc_pkg::OFF_ACC);
		// Enable low: event and clear write must both be ignored
		@(posedge sys_clk);
		clk_en <= 1'b0;
		conv_done <= 1'b1;
		conv_slot <= 2'h0;
		conv_result <= 16'h1111;
		bus_wr <= 1'b1;
		bus_addr <= afc_pkg::OFF_FLAG_CLR;
		bus_wdata <= 32'h00000000;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		bus_wr <= 1'b0;
		clk_en <= 1'b1;
		rd_chk(afc_pkg::OFF_FLAG);
		rd_chk(afc_pkg::OFF_RESULT0);
		for (int i = 0; i < 60; i++) begin
			rnd = lfsr(rnd);
			pulse({1'b0, rnd[5:0]}, rnd[7:6], lfsr(rnd), rnd[8], {25'h0000000, rnd[15:9]});
			rnd = lfsr(rnd);
			rd_chk(8'h20 + {4'h0, rnd[1:0], 2'h0});
			rd_chk(afc_pkg::OFF_ACC);
			rd_chk(afc_pkg::OFF_FLAG);
		end
		wrap_up;
	end
endmodule
